// *** hdl/key_io_ports.sv ***
/*
  Key input port with edge-selected group interrupts, and a 12-bit
  general output port with float control and two special clock outputs.
  Assumes an APB master on pclk; pins and oscillator clocks are sampled
  on pclk, so the oscillator clocks must be well below 12.5 MHz.
*/
// Implementation choice: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module key_io_ports #(
  parameter bit OD_GROUP1 = 1'b0,
  parameter bit OD_GROUP2 = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [key_io_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] input_group0_pins,
  input wire logic [3:0] input_group1_pins,
  output logic timer_shared_input_pin,
  input wire logic timer_clock_output,
  input wire logic low_speed_osc_clock,
  input wire logic high_speed_osc_clock,
  output logic group0_irq,
  output logic group1_irq,
  output logic [3:0] output_group0_pins,
  output logic [3:0] output_group0_oe,
  output logic [3:0] output_group1_pins,
  output logic [3:0] output_group1_oe,
  output logic [3:0] output_group2_pins,
  output logic [3:0] output_group2_oe
);
  logic [9:0] sync1_q;
  logic [9:0] sync2_q;
  logic [3:0] sel_q [2];
  logic [3:0] cmp_q [2];
  logic [3:0] pin_lvl [2];
  logic [1:0] mask_q;
  logic [1:0] flag_q;
  logic [1:0] match_q;
  logic [1:0] match_now;
  logic [1:0] cond;
  logic [3:0] hiz0_q;
  logic [3:0] data0_q;
  logic [3:0] data1_q;
  logic [3:0] data2_q;
  logic hiz1_q;
  logic hiz2_q;
  logic freq_clock_output_on_q;
  logic timer_clock_output_on_q;
  logic [1:0] fofq_q;
  logic freq_clock_output_gate_q;
  logic timer_clock_output_gate_q;
  logic ls_prev_q;
  logic [key_io_pkg::DIV_W-1:0] div_q;
  logic freq_src;
  logic [15:0] idx;
  logic aligned;
  logic wr;
  logic rd_hit;
  logic [31:0] rd_val;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Keys and oscillator clocks are asynchronous; the second stage is the
  // only reader of the first.
  // two-flop synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 10'h000;
      sync2_q <= 10'h000;
    end else begin
      sync1_q <= {high_speed_osc_clock, low_speed_osc_clock,
                  input_group1_pins, input_group0_pins};
      sync2_q <= sync1_q;
    end
  end

  assign pin_lvl[0] = sync2_q[3:0];
  assign pin_lvl[1] = sync2_q[7:4];
  assign timer_shared_input_pin = sync2_q[7];

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // Zero-wait slave: read data is captured in the setup cycle.
  assign idx = paddr[key_io_pkg::ADDR_W-1:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign wr = psel & penable & pwrite & rd_hit;
  assign pready = psel & penable;
  assign pslverr = psel & penable & ~rd_hit;

  // Read mux; also flags whether the address is mapped.
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = aligned;
    case (idx)
      key_io_pkg::IDX_G0_SEL: rd_val[3:0] = sel_q[0];
      key_io_pkg::IDX_G0_LVL: rd_val[3:0] = pin_lvl[0];
      key_io_pkg::IDX_G0_CMP: rd_val[3:0] = cmp_q[0];
      key_io_pkg::IDX_G1_SEL: rd_val[3:0] = sel_q[1];
      key_io_pkg::IDX_G1_LVL: rd_val[3:0] = pin_lvl[1];
      key_io_pkg::IDX_G1_CMP: rd_val[3:0] = cmp_q[1];
      key_io_pkg::IDX_G0_MASK: rd_val[0] = mask_q[0];
      key_io_pkg::IDX_G1_MASK: rd_val[0] = mask_q[1];
      key_io_pkg::IDX_G0_FLAG: rd_val[0] = flag_q[0];
      key_io_pkg::IDX_G1_FLAG: rd_val[0] = flag_q[1];
      key_io_pkg::IDX_OUT0_HIZ: rd_val[3:0] = hiz0_q;
      key_io_pkg::IDX_OUT0_DATA: rd_val[3:0] = data0_q;
      key_io_pkg::IDX_OUT1_HIZ: rd_val[0] = hiz1_q;
      key_io_pkg::IDX_OUT1_DATA: rd_val[3:0] = data1_q;
      key_io_pkg::IDX_OUT2_HIZ: rd_val[0] = hiz2_q;
      key_io_pkg::IDX_OUT2_DATA: rd_val[3:0] = data2_q;
      key_io_pkg::IDX_FREQ_CTL: begin
        rd_val[key_io_pkg::FREQ_CLOCK_OUTPUT_ON_BIT] = freq_clock_output_on_q;
        rd_val[key_io_pkg::FOFQ_LSB +: 2] = fofq_q;
      end
      key_io_pkg::IDX_TIMER_CTL: rd_val[key_io_pkg::TIMER_CLOCK_OUTPUT_ON_BIT] = timer_clock_output_on_q;
      default: rd_hit = 1'b0;
    endcase
  end

  // Read data register; loaded in the setup cycle and held.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable) begin
      prdata <= rd_val;
    end
  end

  // ----------------------------------------------------------------
  // Input interrupt control registers
  // ----------------------------------------------------------------
  // Level registers have no write path, so writes to them vanish.
  // control bits reset to 0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q[0] <= key_io_pkg::SEL_RST;
      sel_q[1] <= key_io_pkg::SEL_RST;
      cmp_q[0] <= key_io_pkg::CMP_RST;
      cmp_q[1] <= key_io_pkg::CMP_RST;
      mask_q <= 2'h0;
    end else if (wr) begin
      case (idx)
        key_io_pkg::IDX_G0_SEL: sel_q[0] <= pwdata[3:0];
        key_io_pkg::IDX_G0_CMP: cmp_q[0] <= pwdata[3:0];
        key_io_pkg::IDX_G1_SEL: sel_q[1] <= pwdata[3:0];
        key_io_pkg::IDX_G1_CMP: cmp_q[1] <= pwdata[3:0];
        key_io_pkg::IDX_G0_MASK: mask_q[0] <= pwdata[0];
        key_io_pkg::IDX_G1_MASK: mask_q[1] <= pwdata[0];
        default: mask_q <= mask_q;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Edge condition and factor flags
  // ----------------------------------------------------------------
  // A group matches when every selected pin equals its compare bit, so
  // compare 1 waits high for a fall and compare 0 waits low for a rise.
  always_comb begin
    for (int g = 0; g < 2; g++) begin
      match_now[g] = ~|((pin_lvl[g] ^ cmp_q[g]) & sel_q[g]);
      cond[g] = match_q[g] & ~match_now[g];
    end
  end

  // Match history starts true since nothing is selected after reset.
  // The set term wins over a clear written in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_q <= 2'h3;
      flag_q <= 2'h0;
    end else begin
      match_q <= match_now;
      flag_q[0] <= cond[0] | (flag_q[0] &
        ~(wr & (idx == key_io_pkg::IDX_G0_FLAG) & pwdata[0]));
      flag_q[1] <= cond[1] | (flag_q[1] &
        ~(wr & (idx == key_io_pkg::IDX_G1_FLAG) & pwdata[0]));
    end
  end

  // Processor requests, registered from flag and mask.
  // request needs flag and mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      group0_irq <= 1'b0;
      group1_irq <= 1'b0;
    end else begin
      group0_irq <= flag_q[0] & mask_q[0];
      group1_irq <= flag_q[1] & mask_q[1];
    end
  end

  // ----------------------------------------------------------------
  // Output port registers
  // ----------------------------------------------------------------
  // reset data 1, float 0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hiz0_q <= key_io_pkg::HIZ_RST;
      data0_q <= key_io_pkg::DATA_RST;
      data1_q <= key_io_pkg::DATA_RST;
      data2_q <= key_io_pkg::DATA_RST;
      hiz1_q <= 1'b0;
      hiz2_q <= 1'b0;
      freq_clock_output_on_q <= 1'b0;
      timer_clock_output_on_q <= 1'b0;
      fofq_q <= key_io_pkg::FOFQ_RST;
    end else if (wr) begin
      case (idx)
        key_io_pkg::IDX_OUT0_HIZ: hiz0_q <= pwdata[3:0];
        key_io_pkg::IDX_OUT0_DATA: data0_q <= pwdata[3:0];
        key_io_pkg::IDX_OUT1_HIZ: hiz1_q <= pwdata[0];
        key_io_pkg::IDX_OUT1_DATA: data1_q <= pwdata[3:0];
        key_io_pkg::IDX_OUT2_HIZ: hiz2_q <= pwdata[0];
        key_io_pkg::IDX_OUT2_DATA: data2_q <= pwdata[3:0];
        key_io_pkg::IDX_FREQ_CTL: begin
          freq_clock_output_on_q <= pwdata[key_io_pkg::FREQ_CLOCK_OUTPUT_ON_BIT];
          fofq_q <= pwdata[key_io_pkg::FOFQ_LSB +: 2];
        end
        key_io_pkg::IDX_TIMER_CTL: timer_clock_output_on_q <= pwdata[key_io_pkg::TIMER_CLOCK_OUTPUT_ON_BIT];
        default: timer_clock_output_on_q <= timer_clock_output_on_q;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Frequency clock source
  // ----------------------------------------------------------------
  // The low-speed clock is divided by counting its sampled rising edges.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ls_prev_q <= 1'b0;
      div_q <= '0;
    end else begin
      ls_prev_q <= sync2_q[8];
      if (sync2_q[8] & ~ls_prev_q) begin
        div_q <= div_q + 1'b1;
      end
    end
  end

  always_comb begin
    case (fofq_q)
      key_io_pkg::FQ_HIGH: freq_src = sync2_q[9];
      key_io_pkg::FQ_LOW: freq_src = sync2_q[8];
      key_io_pkg::FQ_DIV8: freq_src = div_q[key_io_pkg::DIV8_TAP];
      default: freq_src = div_q[key_io_pkg::DIV64_TAP];
    endcase
  end

  // Enables move only while their source is low, so switching never
  // chops a high phase into a runt pulse.
  // glitch-free gating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freq_clock_output_gate_q <= 1'b0;
      timer_clock_output_gate_q <= 1'b0;
    end else begin
      if (!freq_src) begin
        freq_clock_output_gate_q <= freq_clock_output_on_q;
      end
      if (!timer_clock_output) begin
        timer_clock_output_gate_q <= timer_clock_output_on_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  // Open-drain groups only sink; a 1 is left to the external pull-up.
  // drive style per group
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      output_group0_pins <= 4'hF;
      output_group0_oe <= 4'hF;
      output_group1_pins <= OD_GROUP1 ? 4'h0 : 4'hF;
      output_group1_oe <= OD_GROUP1 ? 4'h0 : 4'hF;
      output_group2_pins <= OD_GROUP2 ? 4'h0 : 4'hF;
      output_group2_oe <= OD_GROUP2 ? 4'h0 : 4'hF;
    end else begin
      output_group0_pins <= {
        data0_q[3] & (freq_clock_output_gate_q ? freq_src : 1'b1),
        data0_q[2] & (timer_clock_output_gate_q ? timer_clock_output : 1'b1),
        data0_q[1:0]};
      output_group0_oe <= ~hiz0_q;
      output_group1_pins <= OD_GROUP1 ? 4'h0 : data1_q;
      output_group1_oe <= {4{~hiz1_q}} & (OD_GROUP1 ? ~data1_q : 4'hF);
      output_group2_pins <= OD_GROUP2 ? 4'h0 : data2_q;
      output_group2_oe <= {4{~hiz2_q}} & (OD_GROUP2 ? ~data2_q : 4'hF);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_g0_fire;
    cond[0] && mask_q[0];
  endsequence
  sequence s_g0_raise;
    flag_q[0] ##1 group0_irq;
  endsequence

  a_g0_fire_req: assert property (s_g0_fire |=> s_g0_raise)
    else $error("group 0 condition did not raise flag and request");
  a_flag_set_nomask: assert property (cond[1] |=> flag_q[1])
    else $error("group 1 flag not set by condition");
  a_flag_clear_w1: assert property (wr && idx == key_io_pkg::IDX_G1_FLAG
    && pwdata[0] && !cond[1] |=> !flag_q[1])
    else $error("group 1 flag not cleared by write of 1");
  a_flag_hold_w0: assert property (flag_q[0] && !(wr && pwdata[0])
    |=> flag_q[0])
    else $error("group 0 flag lost without a clear");
  a_irq_mask_off: assert property (!mask_q[1] |=> !group1_irq)
    else $error("masked group 1 request asserted");
  a_unsel_quiet: assert property (sel_q[0] == 4'h0 && !flag_q[0] |=> !flag_q[0])
    else $error("group 0 flag set with no pin selected");
  a_mismatch_hold: assert property (!match_q[1] && !flag_q[1] |=> !flag_q[1])
    else $error("group 1 flag set from a mismatch state");
  a_level_read: assert property (psel && !penable && aligned
    && idx == key_io_pkg::IDX_G0_LVL
    |=> prdata[3:0] == $past(sync2_q[3:0]))
    else $error("level read differs from pins");
  a_float_release: assert property (hiz0_q[1] |=> !output_group0_oe[1])
    else $error("floated pin still driven");
  a_data_drive: assert property (!hiz0_q[0] |=> output_group0_oe[0]
    && output_group0_pins[0] == $past(data0_q[0]))
    else $error("driving pin does not follow data");
  a_special_low: assert property (!data0_q[3] |=> !output_group0_pins[3])
    else $error("frequency pin not low with data 0");
  a_special_high: assert property (data0_q[2] && !timer_clock_output_gate_q
    |=> output_group0_pins[2])
    else $error("timer pin not high while gated off");

endmodule : key_io_ports
`default_nettype wire

// *** hdl/key_io_pkg.sv ***
/*
  Constants for the key input and general output port block: register
  indices, field positions, reset values and divider taps.
  Assumes an APB master with 32-bit data; byte address = 4 * index.
*/
`default_nettype none
package key_io_pkg;
  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index).
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_FREQ_CTL = 16'hFF06;
  localparam logic [15:0] IDX_G0_SEL = 16'hFF20;
  localparam logic [15:0] IDX_G0_LVL = 16'hFF21;
  localparam logic [15:0] IDX_G0_CMP = 16'hFF22;
  localparam logic [15:0] IDX_G1_SEL = 16'hFF24;
  localparam logic [15:0] IDX_G1_LVL = 16'hFF25;
  localparam logic [15:0] IDX_G1_CMP = 16'hFF26;
  localparam logic [15:0] IDX_OUT0_HIZ = 16'hFF30;
  localparam logic [15:0] IDX_OUT0_DATA = 16'hFF31;
  localparam logic [15:0] IDX_OUT1_HIZ = 16'hFF32;
  localparam logic [15:0] IDX_OUT1_DATA = 16'hFF33;
  localparam logic [15:0] IDX_OUT2_HIZ = 16'hFF34;
  localparam logic [15:0] IDX_OUT2_DATA = 16'hFF35;
  localparam logic [15:0] IDX_TIMER_CTL = 16'hFFC1;
  localparam logic [15:0] IDX_G0_MASK = 16'hFFE4;
  localparam logic [15:0] IDX_G1_MASK = 16'hFFE5;
  localparam logic [15:0] IDX_G0_FLAG = 16'hFFF4;
  localparam logic [15:0] IDX_G1_FLAG = 16'hFFF5;
  localparam int ADDR_W = 18;
  // ----------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------
  localparam int FREQ_CLOCK_OUTPUT_ON_BIT = 3;
  localparam int TIMER_CLOCK_OUTPUT_ON_BIT = 2;
  localparam int FOFQ_LSB = 0;
  // ----------------------------------------------------------------
  // Reset values.
  // ----------------------------------------------------------------
  localparam logic [3:0] SEL_RST = 4'h0;
  localparam logic [3:0] CMP_RST = 4'h0;
  localparam logic [3:0] HIZ_RST = 4'h0;
  localparam logic [3:0] DATA_RST = 4'hF;
  localparam logic [1:0] FOFQ_RST = 2'h0;
  // ----------------------------------------------------------------
  // Frequency select codes and divider taps.
  // ----------------------------------------------------------------
  localparam logic [1:0] FQ_DIV64 = 2'h0;
  localparam logic [1:0] FQ_DIV8 = 2'h1;
  localparam logic [1:0] FQ_LOW = 2'h2;
  localparam logic [1:0] FQ_HIGH = 2'h3;
  localparam int DIV_W = 6;
  localparam int DIV8_TAP = 2;
  localparam int DIV64_TAP = 5;
endpackage : key_io_pkg
`default_nettype wire

// *** sim/key_pins_model.sv ***
/*
  Far-side model for the key and output port block: keys and switches
  on the input pins, the timer clock and both oscillator clocks.
  Assumes the bench sets the wanted key levels off the pclk edge.
*/
`timescale 1ns/10ps
`default_nettype none
module key_pins_model (
  input wire logic [7:0] key_level,
  output logic [3:0] input_group0_pins,
  output logic [3:0] input_group1_pins,
  output logic timer_clock_output,
  output var logic low_speed_osc_clock,
  output var logic high_speed_osc_clock
);
  // Keys are clean levels; no bounce is modelled, and the sync flops inside only synchronise.
  assign input_group0_pins = key_level[3:0];
  assign input_group1_pins = key_level[7:4];

  // Clock sources with half periods that are multiples of 40 ns, so their edges fall on pclk falling edges.
  logic tmr_q = 1'b0;
  initial low_speed_osc_clock = 1'b0;
  // high oscillator stable
  // The fast oscillator runs from time zero, so it is settled before any use.
  initial high_speed_osc_clock = 1'b0;
  always #640 low_speed_osc_clock = ~low_speed_osc_clock;
  always #120 high_speed_osc_clock = ~high_speed_osc_clock;
  always #200 tmr_q = ~tmr_q;
  assign timer_clock_output = tmr_q;
endmodule : key_pins_model
`default_nettype wire

// *** sim/testbench.sv ***
/*
  Self-checking bench for the key input and general output port block.
  Assumes the design's registers sit one per word, byte address four
  times the index, and answer over APB with no fixed wait count.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin miscompares++; \
  $display("unexpected %s: expected %h seen %h", nm, exp, got); end end
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [7:0] key_level;
  logic [3:0] k0, k1, p0, o0, p1, o1, p2, o2;
  logic tshare, tclk, losc, hosc, irq0, irq1;
  int n_checks = 0;
  int miscompares = 0;
  int cnt, e, q;
  logic [15:0] ridx [16] = '{key_io_pkg::IDX_G0_SEL, key_io_pkg::IDX_G0_CMP, key_io_pkg::IDX_G1_SEL,
    key_io_pkg::IDX_G1_CMP, key_io_pkg::IDX_G0_MASK, key_io_pkg::IDX_G1_MASK, key_io_pkg::IDX_G0_FLAG,
    key_io_pkg::IDX_G1_FLAG, key_io_pkg::IDX_OUT0_HIZ, key_io_pkg::IDX_OUT0_DATA, key_io_pkg::IDX_OUT1_HIZ,
    key_io_pkg::IDX_OUT1_DATA, key_io_pkg::IDX_OUT2_HIZ, key_io_pkg::IDX_OUT2_DATA,
    key_io_pkg::IDX_FREQ_CTL, key_io_pkg::IDX_TIMER_CTL};
  logic [31:0] rexp [16] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 32'h0000000F, 0, 32'h0000000F, 0, 32'h0000000F, 0, 0};
  int fexp [4] = '{2, 16, 128, 682};

  key_io_ports dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .input_group0_pins(k0), .input_group1_pins(k1), .timer_shared_input_pin(tshare),
    .timer_clock_output(tclk), .low_speed_osc_clock(losc), .high_speed_osc_clock(hosc),
    .group0_irq(irq0), .group1_irq(irq1), .output_group0_pins(p0), .output_group0_oe(o0),
    .output_group1_pins(p1), .output_group1_oe(o1), .output_group2_pins(p2), .output_group2_oe(o2));
  key_pins_model pins (.key_level(key_level), .input_group0_pins(k0), .input_group1_pins(k1),
    .timer_clock_output(tclk), .low_speed_osc_clock(losc), .high_speed_osc_clock(hosc));

  // Clock at 25 MHz.
  always #20 pclk = ~pclk;

  // --------------------------------------------------------------
  // Bus and helper tasks
  // --------------------------------------------------------------
  task apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rd_chk(input string nm, input logic [15:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h00000000);
    `CHK(nm, exp, rdat)
  endtask : rd_chk

  // Counts rising edges on one group-0 pin; unknowns never count.
  task edges(input int b, input int n);
    logic p;
    cnt = 0;
    p = p0[b];
    repeat (n) begin
      @(posedge pclk);
      if (p === 1'b0 && p0[b] === 1'b1) cnt++;
      p = p0[b];
    end
  endtask : edges

  task conclude;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude

  // Watchdog sized well beyond the roughly 30000 cycles the tests need.
  initial begin
    repeat (60000) @(posedge pclk);
    miscompares++;
    conclude();
  end

  // Main sequence of tests.
  initial begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = '0; pwdata = '0; key_level = 8'h00;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    `CHK("reset_pins", 12'hFFF, {p0 & o0, p1 & o1, p2 & o2})
    for (int i = 0; i < 16; i++) rd_chk("reset_reg", ridx[i], rexp[i]);
    apb(1'b0, 16'hFF10, 32'h00000000);
    `CHK("unmapped_err", 1'b1, rerr)
    $display("test reset done");
    key_level <= 8'h5A;
    repeat (4) @(posedge pclk);
    rd_chk("lvl0", key_io_pkg::IDX_G0_LVL, 32'h0000000A);
    rd_chk("lvl1", key_io_pkg::IDX_G1_LVL, 32'h00000005);
    apb(1'b1, key_io_pkg::IDX_G0_LVL, 32'h00000005);
    rd_chk("lvl0_ro", key_io_pkg::IDX_G0_LVL, 32'h0000000A);
    `CHK("tshare_lo", 1'b0, tshare)
    $display("test levels done");
    key_level <= 8'h00;
    apb(1'b1, key_io_pkg::IDX_G0_SEL, 32'h00000009);
    apb(1'b1, key_io_pkg::IDX_G0_CMP, 32'h00000000);
    repeat (6) @(posedge pclk);
    key_level <= 8'h02;
    repeat (6) @(posedge pclk);
    rd_chk("flag_unsel", key_io_pkg::IDX_G0_FLAG, 32'h00000000);
    key_level <= 8'h0A;
    repeat (6) @(posedge pclk);
    rd_chk("flag_rise", key_io_pkg::IDX_G0_FLAG, 32'h00000001);
    `CHK("irq0_masked", 1'b0, irq0)
    apb(1'b1, key_io_pkg::IDX_G0_MASK, 32'h00000001);
    repeat (2) @(posedge pclk);
    `CHK("irq0_on", 1'b1, irq0)
    apb(1'b1, key_io_pkg::IDX_G0_FLAG, 32'h00000000);
    rd_chk("flag_w0", key_io_pkg::IDX_G0_FLAG, 32'h00000001);
    apb(1'b1, key_io_pkg::IDX_G0_FLAG, 32'h00000001);
    repeat (2) @(posedge pclk);
    `CHK("irq0_off", 1'b0, irq0)
    key_level <= 8'h0B;
    repeat (6) @(posedge pclk);
    rd_chk("flag_mm", key_io_pkg::IDX_G0_FLAG, 32'h00000000);
    key_level <= 8'h8B;
    repeat (6) @(posedge pclk);
    `CHK("tshare_hi", 1'b1, tshare)
    apb(1'b1, key_io_pkg::IDX_G1_CMP, 32'h00000008);
    apb(1'b1, key_io_pkg::IDX_G1_SEL, 32'h00000008);
    apb(1'b1, key_io_pkg::IDX_G1_MASK, 32'h00000001);
    repeat (6) @(posedge pclk);
    rd_chk("flag1_match", key_io_pkg::IDX_G1_FLAG, 32'h00000000);
    key_level <= 8'h0B;
    repeat (6) @(posedge pclk);
    rd_chk("flag1_fall", key_io_pkg::IDX_G1_FLAG, 32'h00000001);
    `CHK("irq1_on", 1'b1, irq1)
    apb(1'b1, key_io_pkg::IDX_G1_FLAG, 32'h00000001);
    // Group 0 returns to a match and then leaves it with its mask open.
    key_level <= 8'h00;
    repeat (6) @(posedge pclk);
    key_level <= 8'h08;
    repeat (6) @(posedge pclk);
    `CHK("irq0_again", 1'b1, irq0)
    rd_chk("flag0_again", key_io_pkg::IDX_G0_FLAG, 32'h00000001);
    apb(1'b1, key_io_pkg::IDX_G0_FLAG, 32'h00000001);
    $display("test interrupts done");
    apb(1'b1, key_io_pkg::IDX_OUT0_HIZ, 32'h00000005);
    apb(1'b1, key_io_pkg::IDX_OUT0_DATA, 32'h00000003);
    apb(1'b1, key_io_pkg::IDX_OUT1_HIZ, 32'h00000001);
    apb(1'b1, key_io_pkg::IDX_OUT1_DATA, 32'h00000006);
    apb(1'b1, key_io_pkg::IDX_OUT2_DATA, 32'h00000009);
    repeat (2) @(posedge pclk);
    `CHK("oe_all", 12'hA0F, {o0, o1, o2})
    `CHK("out_data", 8'h29, {p0 & o0, p2})
    apb(1'b1, key_io_pkg::IDX_OUT1_HIZ, 32'h00000000);
    repeat (2) @(posedge pclk);
    `CHK("out1", 8'hF6, {o1, p1})
    $display("test outputs done");
    apb(1'b1, key_io_pkg::IDX_OUT0_HIZ, 32'h00000000);
    apb(1'b1, key_io_pkg::IDX_OUT0_DATA, 32'h0000000F);
    apb(1'b1, key_io_pkg::IDX_TIMER_CTL, 32'h00000004);
    repeat (100) @(posedge pclk);
    edges(2, 2000);
    `CHK("timer_clock_output_edges", 1'b1, cnt >= 180 && cnt <= 220)
    apb(1'b1, key_io_pkg::IDX_TIMER_CTL, 32'h00000000);
    repeat (100) @(posedge pclk);
    edges(2, 500);
    `CHK("timer_clock_output_off", 2'b01, {cnt != 0, p0[2]})
    // Each frequency code is given time for a full slow low phase before counting.
    for (q = 0; q < 4; q++) begin
      apb(1'b1, key_io_pkg::IDX_FREQ_CTL, 32'h00000008 | q);
      repeat (2200) @(posedge pclk);
      edges(3, 4096);
      e = fexp[q];
      `CHK("freq_clock_output_edges", 1'b1, cnt >= e - e / 8 - 1 && cnt <= e + e / 8 + 1)
    end
    apb(1'b1, key_io_pkg::IDX_OUT0_DATA, 32'h00000007);
    repeat (4) @(posedge pclk);
    edges(3, 300);
    `CHK("freq_clock_output_data0", 2'b00, {cnt != 0, p0[3]})
    apb(1'b1, key_io_pkg::IDX_OUT0_DATA, 32'h0000000F);
    apb(1'b1, key_io_pkg::IDX_OUT0_HIZ, 32'h00000008);
    repeat (4) @(posedge pclk);
    `CHK("freq_clock_output_float", 1'b0, o0[3])
    $display("test special outputs done");
    conclude();
  end
endmodule : testbench
`default_nettype wire
